// ### logic/mstat_counters.sv
// ethernet mac receive and transmit statistics counter bank
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "mstat_defs.svh"
module mstat_counters (
   input wire logic clk,
   input wire logic rst_n,
   // receive frame summary, one pulse per completed frame
   input wire logic rx_done,
   input wire mstat_pkg::mstat_len_t rx_len,
   input wire logic rx_crc_ok,
   input wire logic rx_link_cut,
   input wire logic rx_filter_pass,
   input wire logic rx_is_bcast,
   input wire logic rx_is_mcast,
   input wire logic rx_is_fc,
   input wire logic rx_missed,
   input wire logic rx_vlan_tagged,
   input wire mstat_pkg::mstat_len_t rx_long_max,
   // one pulse per dropped copy for want of a host buffer
   input wire logic rx_nobuf_drop,
   input wire logic rx_nobuf_is_fc,
   // transmit frame summary
   input wire logic tx_done,
   input wire mstat_pkg::mstat_len_t tx_len,
   input wire logic tx_ok,
   input wire logic tx_is_fc,
   // axi4-lite slave
   input wire logic [15:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [15:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import mstat_pkg::*;

   mstat_word_t cnt_512_reg, cnt_1024_reg, cnt_good_reg, cnt_bcast_reg;
   mstat_word_t cnt_mcast_reg, cnt_tx_reg, cnt_nobuf_reg, cnt_under_reg;
   mstat_oct_t rx_oct_reg, tx_oct_reg;
   mstat_word_t rx_hi_snap_reg, tx_hi_snap_reg;
   logic [4:0] ctrl_reg;
   logic aw_held_reg, w_held_reg;
   logic [15:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   mstat_rd_e rd_state_reg;
   logic [15:0] rd_addr_reg;

   // saturating 32-bit step, shared by every event counter
   function automatic mstat_word_t bump(input mstat_word_t v);
      bump = (v == `MSTAT_ONES32) ? v : v + 32'h0000_0001;
   endfunction

   // clear-on-read wins only for the old value; a same-cycle event survives
   function automatic mstat_word_t step(input mstat_word_t v,
                                        input logic clr, input logic inc);
      mstat_word_t base;
      base = clr ? `MSTAT_ZERO32 : v;
      step = inc ? bump(base) : base;
   endfunction

   // ---------------- register bus ----------------
   logic wr_fire, rd_take, rd_fire;
   logic rx_en, tx_en;
   assign rx_en = ctrl_reg[`MSTAT_CTRL_RX_EN];
   assign tx_en = ctrl_reg[`MSTAT_CTRL_TX_EN];

   assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
   assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 16'h0000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         w_held_reg <= 1'b0;
         w_data_reg <= `MSTAT_ZERO32;
         w_strb_reg <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held_reg <= 1'b0;
      end
   end

   // counters are read-only; only the control word accepts writes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `MSTAT_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (aw_addr_reg == `MSTAT_OFF_CTRL) ?
                        `MSTAT_RESP_OKAY : `MSTAT_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= `MSTAT_CTRL_RESET;
      end else if (wr_fire && aw_addr_reg == `MSTAT_OFF_CTRL
                   && w_strb_reg[0]) begin
         ctrl_reg <= w_data_reg[4:0];
      end
   end

   // read: accept, answer two cycles later, one read outstanding
   assign s_axi_arready = (rd_state_reg == MSTAT_RD_IDLE);
   assign rd_take = s_axi_arvalid && s_axi_arready;
   assign rd_fire = (rd_state_reg == MSTAT_RD_RESP);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_state_reg <= MSTAT_RD_IDLE;
         rd_addr_reg <= 16'h0000;
      end else begin
         case (rd_state_reg)
            MSTAT_RD_IDLE: begin
               if (rd_take) begin
                  rd_addr_reg <= s_axi_araddr;
                  rd_state_reg <= MSTAT_RD_RESP;
               end
            end
            MSTAT_RD_RESP: rd_state_reg <= MSTAT_RD_WAIT;
            MSTAT_RD_WAIT: begin
               if (s_axi_rready) begin
                  rd_state_reg <= MSTAT_RD_IDLE;
               end
            end
            default: rd_state_reg <= MSTAT_RD_IDLE;
         endcase
      end
   end

   // one-cycle clear strobe per register, raised when the data is latched
   function automatic logic hit(input logic [15:0] off);
      hit = rd_fire && (rd_addr_reg == off);
   endfunction

   logic clr_512, clr_1024, clr_good, clr_bcast, clr_mcast, clr_tx;
   logic clr_nobuf, clr_under, rd_rx_lo, rd_rx_hi, rd_tx_lo, rd_tx_hi;
   assign clr_512 = hit(`MSTAT_OFF_RX_512_1023);
   assign clr_1024 = hit(`MSTAT_OFF_RX_1024_MAX);
   assign clr_good = hit(`MSTAT_OFF_RX_GOOD);
   assign clr_bcast = hit(`MSTAT_OFF_RX_BCAST);
   assign clr_mcast = hit(`MSTAT_OFF_RX_MCAST);
   assign clr_tx = hit(`MSTAT_OFF_TX_GOOD);
   assign clr_nobuf = hit(`MSTAT_OFF_RX_NOBUF);
   assign clr_under = hit(`MSTAT_OFF_RX_UNDER);
   assign rd_rx_lo = hit(`MSTAT_OFF_RX_OCT_LO);
   assign rd_rx_hi = hit(`MSTAT_OFF_RX_OCT_HI);
   assign rd_tx_lo = hit(`MSTAT_OFF_TX_OCT_LO);
   assign rd_tx_hi = hit(`MSTAT_OFF_TX_OCT_HI);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= `MSTAT_ZERO32;
         s_axi_rresp <= `MSTAT_RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `MSTAT_RESP_OKAY;
         case (rd_addr_reg)
            `MSTAT_OFF_RX_512_1023: s_axi_rdata <= cnt_512_reg;
            `MSTAT_OFF_RX_1024_MAX: s_axi_rdata <= cnt_1024_reg;
            `MSTAT_OFF_RX_GOOD: s_axi_rdata <= cnt_good_reg;
            `MSTAT_OFF_RX_BCAST: s_axi_rdata <= cnt_bcast_reg;
            `MSTAT_OFF_RX_MCAST: s_axi_rdata <= cnt_mcast_reg;
            `MSTAT_OFF_TX_GOOD: s_axi_rdata <= cnt_tx_reg;
            `MSTAT_OFF_RX_OCT_LO: s_axi_rdata <= rx_oct_reg[31:0];
            `MSTAT_OFF_RX_OCT_HI: s_axi_rdata <= rx_hi_snap_reg;
            `MSTAT_OFF_TX_OCT_LO: s_axi_rdata <= tx_oct_reg[31:0];
            `MSTAT_OFF_TX_OCT_HI: s_axi_rdata <= tx_hi_snap_reg;
            `MSTAT_OFF_RX_NOBUF: s_axi_rdata <= cnt_nobuf_reg;
            `MSTAT_OFF_RX_UNDER: s_axi_rdata <= cnt_under_reg;
            `MSTAT_OFF_CTRL: s_axi_rdata <= {27'h0000000, ctrl_reg};
            default: begin
               s_axi_rdata <= `MSTAT_ZERO32;
               s_axi_rresp <= `MSTAT_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------- frame classification ----------------
   logic rx_ok, rx_counted, rx_legal, rx_oversize;
   logic ev_512, ev_1024, ev_good, ev_bcast, ev_mcast, ev_under, ev_tx;
   mstat_len_t top_max, legal_max;

   // vlan limit applies to the top bin; long packets raise the legal limit
   assign top_max = ctrl_reg[`MSTAT_CTRL_EXT_VLAN] ? `MSTAT_LEN_VLAN_MAX
                    : `MSTAT_LEN_STD_MAX;
   assign legal_max = ctrl_reg[`MSTAT_CTRL_LPE] ? rx_long_max
                      : top_max;
   assign rx_oversize = rx_len > legal_max;
   assign rx_legal = rx_len >= `MSTAT_LEN_MIN && !rx_oversize;
   // a frame cut by link loss still counts as good here
   assign rx_ok = rx_crc_ok || rx_link_cut;
   assign rx_counted = rx_done && rx_en && rx_filter_pass
                       && !rx_is_fc && !rx_missed;
   assign ev_512 = rx_counted && rx_crc_ok && rx_len >= `MSTAT_LEN_512
                   && rx_len <= `MSTAT_LEN_1023;
   assign ev_1024 = rx_counted && rx_crc_ok && rx_len >= `MSTAT_LEN_1024
                    && rx_len <= top_max && !rx_oversize;
   assign ev_good = rx_counted && rx_ok && rx_legal;
   assign ev_bcast = rx_done && rx_en && rx_crc_ok && rx_is_bcast
                     && !rx_missed
                     && ctrl_reg[`MSTAT_CTRL_BCAST_EN];
   assign ev_mcast = rx_counted && rx_crc_ok && rx_is_mcast;
   // runts below 25 bytes are not counted as undersize; bcast and mcast apply no length check
   assign ev_under = rx_done && rx_en && rx_filter_pass && rx_crc_ok
                     && rx_len < `MSTAT_LEN_MIN
                     && rx_len >= `MSTAT_LEN_RUNT;
   assign ev_tx = tx_done && tx_en && tx_ok && !tx_is_fc
                  && tx_len >= `MSTAT_LEN_MIN;

   // ---------------- event counters ----------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_512_reg <= `MSTAT_ZERO32;
         cnt_1024_reg <= `MSTAT_ZERO32;
         cnt_good_reg <= `MSTAT_ZERO32;
         cnt_bcast_reg <= `MSTAT_ZERO32;
         cnt_mcast_reg <= `MSTAT_ZERO32;
      end else begin
         cnt_512_reg <= step(cnt_512_reg, clr_512, ev_512);
         cnt_1024_reg <= step(cnt_1024_reg, clr_1024, ev_1024);
         cnt_good_reg <= step(cnt_good_reg, clr_good, ev_good);
         cnt_bcast_reg <= step(cnt_bcast_reg, clr_bcast, ev_bcast);
         cnt_mcast_reg <= step(cnt_mcast_reg, clr_mcast, ev_mcast);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_tx_reg <= `MSTAT_ZERO32;
         cnt_nobuf_reg <= `MSTAT_ZERO32;
         cnt_under_reg <= `MSTAT_ZERO32;
      end else begin
         cnt_tx_reg <= step(cnt_tx_reg, clr_tx, ev_tx);
         // frame still lands in the fifo; this only tallies the drop
         cnt_nobuf_reg <= step(cnt_nobuf_reg, clr_nobuf,
                               rx_nobuf_drop && rx_en
                               && !rx_nobuf_is_fc);
         cnt_under_reg <= step(cnt_under_reg, clr_under, ev_under);
      end
   end

   // ---------------- 64-bit octet counters ----------------
   // the high half is frozen on the low read so the pair is coherent;
   // clearing waits for the high read, a lone low read clears nothing
   function automatic mstat_oct_t oct_step(input mstat_oct_t v,
                                           input logic clr,
                                           input logic inc,
                                           input mstat_len_t len,
                                           input logic sat);
      mstat_oct_t base;
      mstat_oct_t sum;
      base = clr ? 64'h0 : v;
      sum = base + {48'h0, len};
      if (!inc) begin
         oct_step = base;
      end else if (sat && sum < base) begin
         oct_step = `MSTAT_ONES64;
      end else begin
         oct_step = sum;
      end
   endfunction

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_oct_reg <= 64'h0;
         rx_hi_snap_reg <= `MSTAT_ZERO32;
      end else begin
         rx_oct_reg <= oct_step(rx_oct_reg, rd_rx_hi,
                                rx_counted && rx_crc_ok && rx_legal,
                                rx_len, 1'b1);
         if (rd_rx_lo) begin
            rx_hi_snap_reg <= rx_oct_reg[63:32];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_oct_reg <= 64'h0;
         tx_hi_snap_reg <= `MSTAT_ZERO32;
      end else begin
         tx_oct_reg <= oct_step(tx_oct_reg, rd_tx_hi, ev_tx, tx_len,
                                1'b0);
         if (rd_tx_lo) begin
            tx_hi_snap_reg <= tx_oct_reg[63:32];
         end
      end
   end

endmodule // mstat_counters

// ### logic/mstat_defs.svh
// register offsets, field constants and counts for the statistics bank
`ifndef MSTAT_DEFS_SVH
`define MSTAT_DEFS_SVH
`define MSTAT_OFF_RX_512_1023 16'h406C
`define MSTAT_OFF_RX_1024_MAX 16'h4070
`define MSTAT_OFF_RX_GOOD 16'h4074
`define MSTAT_OFF_RX_BCAST 16'h4078
`define MSTAT_OFF_RX_MCAST 16'h407C
`define MSTAT_OFF_TX_GOOD 16'h4080
`define MSTAT_OFF_RX_OCT_LO 16'h4088
`define MSTAT_OFF_RX_OCT_HI 16'h408C
`define MSTAT_OFF_TX_OCT_LO 16'h4090
`define MSTAT_OFF_TX_OCT_HI 16'h4094
`define MSTAT_OFF_RX_NOBUF 16'h40A0
`define MSTAT_OFF_RX_UNDER 16'h40A4
`define MSTAT_OFF_CTRL 16'h40F0
`define MSTAT_CTRL_RX_EN 0
`define MSTAT_CTRL_TX_EN 1
`define MSTAT_CTRL_LPE 2
`define MSTAT_CTRL_EXT_VLAN 3
`define MSTAT_CTRL_BCAST_EN 4
`define MSTAT_CTRL_RESET 5'h10
`define MSTAT_LEN_MIN 16'h0040
`define MSTAT_LEN_512 16'h0200
`define MSTAT_LEN_1023 16'h03FF
`define MSTAT_LEN_1024 16'h0400
`define MSTAT_LEN_STD_MAX 16'h05F2
`define MSTAT_LEN_VLAN_MAX 16'h05F6
`define MSTAT_LEN_RUNT 16'h0019
`define MSTAT_RESP_OKAY 2'h0
`define MSTAT_RESP_SLVERR 2'h2
`define MSTAT_ZERO32 32'h0000_0000
`define MSTAT_ONES32 32'hFFFF_FFFF
`define MSTAT_ONES64 64'hFFFF_FFFF_FFFF_FFFF
`endif

// ### logic/mstat_pkg.sv
// types shared by the statistics bank
package mstat_pkg;
   typedef logic [31:0] mstat_word_t;
   typedef logic [15:0] mstat_len_t;
   typedef logic [63:0] mstat_oct_t;
   typedef enum logic [2:0] {
      MSTAT_RD_IDLE = 3'b001,
      MSTAT_RD_RESP = 3'b010,
      MSTAT_RD_WAIT = 3'b100
   } mstat_rd_e;
endpackage

// ### tb/mstat_counters_assertions.sv
// bus-side assertions and covers for the statistics counter bank
`timescale 1ns/1ps
module mstat_chk (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [15:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking dcb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic ar_hs;
   logic aw_hs;
   assign ar_hs = s_axi_arvalid && s_axi_arready;
   assign aw_hs = s_axi_awvalid && s_axi_awready
                  && s_axi_wvalid && s_axi_wready;
   read_answer_a: assert property (
      ar_hs |-> ##2 s_axi_rvalid)
      else $error("read answer not on time");
   read_cause_a: assert property (
      $rose(s_axi_rvalid) |-> $past(ar_hs, 2))
      else $error("read answer without request");
   read_hold_a: assert property (
      s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read answer not held");
   read_end_a: assert property (
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer not released");
   read_block_a: assert property (
      s_axi_rvalid |-> !s_axi_arready)
      else $error("second read taken");
   unmapped_read_a: assert property (
      ar_hs && s_axi_araddr == 16'h4000 |->
      ##2 (s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000))
      else $error("unmapped read not refused");
   good_read_a: assert property (
      ar_hs && s_axi_araddr == 16'h4074 |-> ##2 s_axi_rresp == 2'h0)
      else $error("counter read refused");
   write_answer_a: assert property (
      aw_hs |-> ##2 s_axi_bvalid)
      else $error("write answer not on time");
   write_hold_a: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer not held");
   write_block_a: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("second write taken");
   cover property (ar_hs && s_axi_araddr == 16'h4000);
   cover property (aw_hs);
   cover property (s_axi_rvalid && !s_axi_rready);
endmodule // mstat_chk
bind mstat_counters mstat_chk u_chk (.clk, .rst_n, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ### tb/mstat_counters_tb_top.sv
// self-checking bench for the statistics counter bank
`timescale 1ns/1ps
`include "mstat_defs.svh"
module mstat_counters_tb_top;
   import mstat_pkg::*;
   logic clk, rst_n, rx_done, rx_crc_ok, rx_link_cut, rx_filter_pass;
   logic rx_is_bcast, rx_is_mcast, rx_is_fc, rx_missed, rx_vlan_tagged;
   logic rx_nobuf_drop, rx_nobuf_is_fc, tx_done, tx_ok, tx_is_fc;
   mstat_len_t rx_len, rx_long_max, tx_len;
   logic [15:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   int mismatches;
   int checks_done;
   logic [15:0] offs [12] = '{16'h406C, 16'h4070, 16'h4074, 16'h4078,
      16'h407C, 16'h4080, 16'h4088, 16'h408C, 16'h4090, 16'h4094,
      16'h40A0, 16'h40A4};
   mstat_counters u_dut (.clk, .rst_n, .rx_done, .rx_len, .rx_crc_ok,
      .rx_link_cut, .rx_filter_pass, .rx_is_bcast, .rx_is_mcast, .rx_is_fc,
      .rx_missed, .rx_vlan_tagged, .rx_long_max, .rx_nobuf_drop,
      .rx_nobuf_is_fc, .tx_done, .tx_len, .tx_ok, .tx_is_fc, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t data %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t resp %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_up();
      mismatches++;
      $display("MISMATCH t=%0t bus answer never came", $time);
      complete_run();
   endtask
   // ready is raised only once valid is seen, so the hold case is exercised
   task automatic axi_write(input logic [15:0] a, input logic [31:0] d,
                            output logic [1:0] r);
      int n;
      logic done;
      n = 0;
      done = 1'b0;
      r = 2'h3;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!done && n < 50) begin
         @(posedge clk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) begin
            r = s_axi_bresp;
            done = 1'b1;
         end
         s_axi_bready <= s_axi_bvalid && !s_axi_bready;
      end
      if (!done) give_up();
   endtask
   task automatic axi_read(input logic [15:0] a, output logic [31:0] d,
                           output logic [1:0] r);
      int n;
      logic done;
      n = 0;
      done = 1'b0;
      d = 32'h0000_0000;
      r = 2'h3;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      while (!done && n < 50) begin
         @(posedge clk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            done = 1'b1;
         end
         s_axi_rready <= s_axi_rvalid && !s_axi_rready;
      end
      if (!done) give_up();
   endtask
   task automatic read_chk(input logic [15:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      axi_read(a, d, r);
      check_data(d, exp);
      check_resp(r, 2'h0);
   endtask
   task automatic set_ctrl(input logic [31:0] v);
      logic [1:0] r;
      axi_write(`MSTAT_OFF_CTRL, v, r);
      check_resp(r, 2'h0);
   endtask
   // flags: crc ok, link cut, filter pass, bcast, mcast, flow control, missed
   task automatic rx_frame(input mstat_len_t len, input logic [6:0] f);
      @(posedge clk);
      rx_len <= len;
      {rx_crc_ok, rx_link_cut, rx_filter_pass, rx_is_bcast, rx_is_mcast,
         rx_is_fc, rx_missed} <= f;
      rx_done <= 1'b1;
      @(posedge clk);
      rx_done <= 1'b0;
   endtask
   task automatic tx_frame(input mstat_len_t len, input logic [1:0] f);
      @(posedge clk);
      tx_len <= len;
      {tx_ok, tx_is_fc} <= f;
      tx_done <= 1'b1;
      @(posedge clk);
      tx_done <= 1'b0;
   endtask
   task automatic nobuf(input logic fc);
      @(posedge clk);
      rx_nobuf_is_fc <= fc;
      rx_nobuf_drop <= 1'b1;
      @(posedge clk);
      rx_nobuf_drop <= 1'b0;
   endtask
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      mismatches = 0;
      checks_done = 0;
      {rst_n, rx_done, rx_crc_ok, rx_link_cut, rx_filter_pass, rx_is_bcast,
         rx_is_mcast, rx_is_fc, rx_missed, rx_vlan_tagged} = '0;
      {rx_nobuf_drop, rx_nobuf_is_fc, tx_done, tx_ok, tx_is_fc} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      s_axi_rready = 1'b0;
      {rx_len, tx_len, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      rx_long_max = 16'h07D0;
      s_axi_wstrb = 4'hF;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      foreach (offs[i]) read_chk(offs[i], 32'h0000_0000);
      axi_read(16'h4000, d, r);
      check_data(d, 32'h0000_0000);
      check_resp(r, 2'h2);
      axi_write(`MSTAT_OFF_RX_GOOD, 32'h0000_0005, r);
      check_resp(r, 2'h2);
      rx_frame(16'h0258, 7'b1010000);
      tx_frame(16'h0064, 2'b10);
      read_chk(`MSTAT_OFF_RX_512_1023, 32'h0000_0000);
      read_chk(`MSTAT_OFF_RX_GOOD, 32'h0000_0000);
      read_chk(`MSTAT_OFF_TX_GOOD, 32'h0000_0000);
      set_ctrl(32'h0000_0013);
      rx_frame(16'h0200, 7'b1010100);
      rx_frame(16'h03FF, 7'b1011000);
      rx_frame(16'h0400, 7'b1010000);
      rx_frame(16'h05F2, 7'b1010000);
      rx_frame(16'h0258, 7'b1010101);
      rx_frame(16'h02BC, 7'b1010110);
      rx_frame(16'h0320, 7'b0110000);
      rx_frame(16'h0064, 7'b1000100);
      rx_frame(16'h0028, 7'b1010000);
      rx_frame(16'h0018, 7'b1010000);
      rx_frame(16'h003F, 7'b0010000);
      rx_frame(16'h0040, 7'b1010000);
      rx_frame(16'h012C, 7'b1011001);
      read_chk(`MSTAT_OFF_RX_512_1023, 32'h0000_0002);
      read_chk(`MSTAT_OFF_RX_1024_MAX, 32'h0000_0002);
      read_chk(`MSTAT_OFF_RX_GOOD, 32'h0000_0006);
      read_chk(`MSTAT_OFF_RX_GOOD, 32'h0000_0000);
      read_chk(`MSTAT_OFF_RX_BCAST, 32'h0000_0001);
      read_chk(`MSTAT_OFF_RX_MCAST, 32'h0000_0001);
      read_chk(`MSTAT_OFF_RX_UNDER, 32'h0000_0001);
      read_chk(`MSTAT_OFF_RX_OCT_LO, 32'h0000_1031);
      read_chk(`MSTAT_OFF_RX_OCT_LO, 32'h0000_1031);
      read_chk(`MSTAT_OFF_RX_OCT_HI, 32'h0000_0000);
      read_chk(`MSTAT_OFF_RX_OCT_LO, 32'h0000_0000);
      tx_frame(16'h0040, 2'b10);
      tx_frame(16'h0040, 2'b11);
      tx_frame(16'h00C8, 2'b00);
      tx_frame(16'h05DC, 2'b10);
      read_chk(`MSTAT_OFF_TX_GOOD, 32'h0000_0002);
      read_chk(`MSTAT_OFF_TX_OCT_LO, 32'h0000_061C);
      read_chk(`MSTAT_OFF_TX_OCT_HI, 32'h0000_0000);
      tx_frame(16'h003F, 2'b10);
      read_chk(`MSTAT_OFF_TX_GOOD, 32'h0000_0000);
      nobuf(1'b0);
      nobuf(1'b1);
      nobuf(1'b0);
      read_chk(`MSTAT_OFF_RX_NOBUF, 32'h0000_0002);
      set_ctrl(32'h0000_001B);
      rx_frame(16'h05F6, 7'b1010000);
      rx_frame(16'h05F7, 7'b1010000);
      read_chk(`MSTAT_OFF_RX_1024_MAX, 32'h0000_0001);
      set_ctrl(32'h0000_0007);
      rx_frame(16'h0640, 7'b1010000);
      rx_frame(16'h00C8, 7'b1011000);
      read_chk(`MSTAT_OFF_RX_GOOD, 32'h0000_0003);
      read_chk(`MSTAT_OFF_RX_BCAST, 32'h0000_0000);
      complete_run();
   end
endmodule // mstat_counters_tb_top
